//--- rtl/pga_zero_cross_level_monitor.sv
// Purpose: Gain update timing, zero-cross flags, peak and level monitors
// Assumes: Samples are valid at the frame clock rising edge
// Notes: Behaviour summary
// Notes on behaviour
// - Common mode: left gain write also loads right; right write loads right only
// - Common mode off: left and right gain writes touch only their own channel
// - One range bit selects line or microphone range for both channels
// - Write and recovery timeout is 513, 1025, 2049 or 4097 samples
// - Write zero-cross on: apply at crossing or timeout; off: apply at once
// - Limiter zero-cross timeout is 129, 258, 516 or 1032 samples
// - Limiter without zero-cross: steps immediate, spaced 1, 2, 4 or 8 samples
// - Limiter zero-cross on: each channel applies at own crossing or timeout
// - Control register resets and ignores writes while power-down pin low
// - Peak magnitude kept per channel in two bytes; high byte top bit zero
// - Reading a peak high byte clears that channel's peak
// - Peaks clear while power-down pin low or converter power off
// - Gated write clears channel done flag; flag sets after the update
// - Rewrite of a waiting channel keeps its timeout count running
// - Write to an idle channel restarts its timeout count
// - Done flags read one when write zero-cross off or limiter on
// - Done flags stay zero during start-up after power-down release while gain power is on
// - Done flags reset by power-down pin, forced one with gain power off
// - Level flag holds highest code; status read clears it
// - Level codes follow the six magnitude thresholds
// - Level flags clear while power-down pin low or converter power off
// - Left level flag behaves like the right one
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module pga_zero_cross_level_monitor
  import pga_zc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic power_down_pin_b,
  input wire logic frame_clk,
  input wire logic [15:0] left_sample,
  input wire logic [15:0] right_sample,
  input wire logic auto_req,
  input wire logic auto_lim,
  input wire logic [6:0] auto_gain,
  output logic [6:0] left_input_gain,
  output logic [6:0] right_input_gain,
  output logic gain_range_select,
  output logic auto_ready,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // Magnitude with the most negative code saturated
  function automatic logic [14:0] mag(input logic [15:0] s);
    logic [15:0] n;
    n = 16'h0000 - s;
    if (!s[15]) return s[14:0];
    if (s == 16'h8000) return 15'h7FFF;
    return n[14:0];
  endfunction

  // Level code for a magnitude
  function automatic logic [2:0] lvl(input logic [14:0] a);
    if (a >= TH6) return 3'h6;
    if (a >= TH5) return 3'h5;
    if (a >= TH4) return 3'h4;
    if (a >= TH3) return 3'h3;
    if (a >= TH2) return 3'h2;
    if (a >= TH1) return 3'h1;
    return 3'h0;
  endfunction

  // Timeout for the source that is pending
  function automatic logic [12:0] tmo(input logic lim, input logic [7:0] c);
    logic [1:0] k;
    k = lim ? c[B_LTM+:2] : c[B_NRTM+:2];
    case ({lim, k})
      3'b000: return NRT0;
      3'b001: return NRT1;
      3'b010: return NRT2;
      3'b011: return NRT3;
      3'b100: return LTO0;
      3'b101: return LTO1;
      3'b110: return LTO2;
      default: return LTO3;
    endcase
  endfunction

  logic pd_m_q, pd_s_q, fc_m_q, fc_s_q, fc_p_q;
  logic [7:0] ctrl_q;
  logic [1:0] pwr_q, auto_q;
  logic [6:0] gain_q [2];
  logic [6:0] tgt_q [2];
  logic [12:0] tmr_q [2];
  logic [1:0] pend_q, srcl_q, sgn_q, done_q;
  logic [14:0] pk_q [2];
  logic [2:0] ovf_q [2];
  logic [3:0] gap_q, init_q;
  phase_t ph_q;
  logic aw_have_q, w_have_q, wstrb0_q;
  logic [5:0] waddr_q;
  logic [7:0] wd_q;
  logic tick, wr_fire, rd_fire, ae, a_zc, a_imm;
  logic wzc, lzc, common_gain_write, ipwr, cpwr, lim_en;
  logic [5:0] ridx;
  logic [1:0] hw, zc;
  logic [14:0] av [2];
  logic [7:0] rd_val;
  logic rd_ok;

  // Pin synchronisers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
      fc_m_q <= 1'b0;
      fc_s_q <= 1'b0;
      fc_p_q <= 1'b0;
    end else begin
      pd_m_q <= power_down_pin_b;
      pd_s_q <= pd_m_q;
      fc_m_q <= frame_clk;
      fc_s_q <= fc_m_q;
      fc_p_q <= fc_s_q;
    end
  end

  // Sample tick and field decode
  assign tick = fc_s_q & ~fc_p_q;
  assign common_gain_write = ctrl_q[B_COMMON_GAIN_WRITE];
  assign wzc = ctrl_q[B_WRITE_ZERO_CROSS_ENABLE];
  assign lzc = ctrl_q[B_LIMITER_ZERO_CROSS_ENABLE];
  assign ipwr = pwr_q[B_IPWR];
  assign cpwr = pwr_q[B_CPWR];
  assign lim_en = auto_q[1];
  assign av[0] = mag(left_sample);
  assign av[1] = mag(right_sample);
  assign zc[0] = tick & (left_sample[15] != sgn_q[0]);
  assign zc[1] = tick & (right_sample[15] != sgn_q[1]);

  // Bus events
  assign wr_fire = aw_have_q & w_have_q & ~bvalid;
  assign rd_fire = arvalid & arready;
  assign ridx = araddr[7:2];
  assign hw[0] = wr_fire & wstrb0_q & (waddr_q == IDX_L_GAIN);
  assign hw[1] = wr_fire & wstrb0_q & ((waddr_q == IDX_R_GAIN) | (hw[0] & common_gain_write));

  // Auto gain requests: limiter step or recovery step
  assign ae = auto_req & lim_en & ipwr;
  assign a_zc = auto_lim ? lzc : wzc;
  assign a_imm = ae & ~a_zc & (~auto_lim | (gap_q == 4'h0));

  // Write address and data capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 6'h00;
      wd_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      awready <= awvalid & ~awready & ~aw_have_q & ~bvalid;
      wready <= wvalid & ~wready & ~w_have_q & ~bvalid;
      if (awvalid & awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= awaddr[7:2];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid & wready) begin
        w_have_q <= 1'b1;
        wd_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (waddr_q > IDX_R_GAIN || waddr_q == 6'h00 ||
                waddr_q == 6'h02) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control, power and auto registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      pwr_q <= POWER_RST;
      auto_q <= AUTO_RST;
    end else if (!pd_s_q) begin
      ctrl_q <= CTRL_RST;
      pwr_q <= POWER_RST;
      auto_q <= AUTO_RST;
    end else if (wr_fire & wstrb0_q) begin
      if (waddr_q == IDX_ZC_CTRL) ctrl_q <= wd_q;
      if (waddr_q == IDX_POWER) pwr_q <= wd_q[1:0];
      if (waddr_q == IDX_AUTO) auto_q <= wd_q[B_LIMITER_ENABLE-:2];
    end
  end

  // Read data mux
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 8'h00;
    case (ridx)
      IDX_POWER: rd_val = {6'h00, pwr_q};
      IDX_ZC_CTRL: rd_val = ctrl_q;
      IDX_L_PK_LO: rd_val = pk_q[0][7:0];
      IDX_L_PK_HI: rd_val = {1'b0, pk_q[0][14:8]};
      IDX_R_PK_LO: rd_val = pk_q[1][7:0];
      IDX_R_PK_HI: rd_val = {1'b0, pk_q[1][14:8]};
      IDX_STATUS: rd_val = {done_q[1], done_q[0], ovf_q[1], ovf_q[0]};
      IDX_AUTO: rd_val = {auto_q, 6'h00};
      IDX_L_GAIN: rd_val = {1'b0, tgt_q[0]};
      IDX_R_GAIN: rd_val = {1'b0, tgt_q[1]};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_val};
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Start-up phase after power-down release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= PH_DOWN;
      init_q <= 4'h0;
    end else if (!pd_s_q) begin
      ph_q <= PH_DOWN;
      init_q <= 4'h0;
    end else begin
      case (ph_q)
        PH_DOWN: ph_q <= PH_INIT;
        PH_INIT: begin
          if (init_q == INIT_TICKS) ph_q <= PH_RUN;
          else if (tick) init_q <= init_q + 4'h1;
        end
        PH_RUN: ph_q <= PH_RUN;
        default: ph_q <= PH_DOWN;
      endcase
    end
  end

  // Limiter step spacing counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 4'h0;
      auto_ready <= 1'b1;
    end else begin
      if (!pd_s_q) gap_q <= 4'h0;
      else if (a_imm & auto_lim) begin
        case (ctrl_q[B_LTM+:2])
          2'b00: gap_q <= GAP0;
          2'b01: gap_q <= GAP1;
          2'b10: gap_q <= GAP2;
          default: gap_q <= GAP3;
        endcase
      end else if (tick && gap_q != 4'h0) gap_q <= gap_q - 4'h1;
      auto_ready <= (gap_q == 4'h0) & ~(a_imm & auto_lim);
    end
  end

  // Per-channel gain update with zero-cross or timeout
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        gain_q[c] <= GAIN_RST;
        tgt_q[c] <= GAIN_RST;
        tmr_q[c] <= 13'h0000;
      end
      pend_q <= 2'b00;
      srcl_q <= 2'b00;
      sgn_q <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (tick) sgn_q[c] <= c == 0 ? left_sample[15] : right_sample[15];
        if (!pd_s_q) begin
          gain_q[c] <= GAIN_RST;
          tgt_q[c] <= GAIN_RST;
          tmr_q[c] <= 13'h0000;
          pend_q[c] <= 1'b0;
          srcl_q[c] <= 1'b0;
        end else if ((ae & a_zc) | (hw[c] & wzc & ~ae)) begin
          tgt_q[c] <= ae ? auto_gain : wd_q[6:0];
          pend_q[c] <= 1'b1;
          srcl_q[c] <= ae & auto_lim;
          if (!pend_q[c]) tmr_q[c] <= 13'h0000;
          else if (tick) tmr_q[c] <= tmr_q[c] + 13'h0001;
        end else if (a_imm | (hw[c] & ~ae)) begin
          gain_q[c] <= a_imm ? auto_gain : wd_q[6:0];
          tgt_q[c] <= a_imm ? auto_gain : wd_q[6:0];
          pend_q[c] <= 1'b0;
        end else if (pend_q[c] & tick) begin
          if (zc[c] || tmr_q[c] >= tmo(srcl_q[c], ctrl_q) - 13'h0001) begin
            gain_q[c] <= tgt_q[c];
            pend_q[c] <= 1'b0;
          end else begin
            tmr_q[c] <= tmr_q[c] + 13'h0001;
          end
        end
      end
    end
  end

  // Completion flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 2'b00;
    end else if (!pd_s_q) begin
      done_q <= 2'b00;
    end else if (!ipwr) begin
      done_q <= 2'b11;
    end else if (ph_q != PH_RUN) begin
      done_q <= 2'b00;
    end else if (!wzc | lim_en) begin
      done_q <= 2'b11;
    end else begin
      done_q <= ~pend_q;
    end
  end

  // Peak and level monitors; a new sample wins over a read clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        pk_q[c] <= 15'h0000;
        ovf_q[c] <= 3'h0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!pd_s_q | !cpwr) begin
          pk_q[c] <= 15'h0000;
          ovf_q[c] <= 3'h0;
        end else begin
          if (tick && (av[c] > pk_q[c] ||
              (rd_fire && ridx == (c == 0 ? IDX_L_PK_HI : IDX_R_PK_HI))))
            pk_q[c] <= av[c];
          else if (rd_fire && ridx == (c == 0 ? IDX_L_PK_HI : IDX_R_PK_HI))
            pk_q[c] <= 15'h0000;
          if (tick && (lvl(av[c]) > ovf_q[c] || (rd_fire && ridx == IDX_STATUS)))
            ovf_q[c] <= lvl(av[c]);
          else if (rd_fire && ridx == IDX_STATUS)
            ovf_q[c] <= 3'h0;
        end
      end
    end
  end

  // Outputs from flops
  assign left_input_gain = gain_q[0];
  assign right_input_gain = gain_q[1];
  assign gain_range_select = ctrl_q[B_GAIN_RANGE_SELECT];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_left_wr;
    hw[0] & ~ae;
  endsequence

  sequence s_idle_wr;
    hw[0] & ~ae & ~pend_q[0] & wzc;
  endsequence

  ctrl_hold_a: assert property (!pd_s_q |=> ctrl_q == CTRL_RST)
    else $error("control register not held at reset value");
  common_wr_a: assert property (s_left_wr ##0 common_gain_write ##0 pd_s_q |=> tgt_q[1] == tgt_q[0])
    else $error("common write did not load right channel");
  sep_wr_a: assert property (hw[0] & ~common_gain_write & ~ae & pd_s_q |=> $stable(tgt_q[1]))
    else $error("left write touched right channel");
  imm_wr_a: assert property (s_left_wr ##0 ~wzc ##0 pd_s_q
    |=> gain_q[0] == $past(wd_q[6:0]))
    else $error("gain not applied at once");
  wr_pend_a: assert property (s_idle_wr ##0 pd_s_q |=> tmr_q[0] == 13'h0000 ##0 pend_q[0]
    ##1 (~pend_q[0] | ~pd_s_q | ph_q != PH_RUN | lim_en | done_q[0] == 1'b0))
    else $error("write did not hold channel pending");
  tmr_keep_a: assert property (pend_q[0] & hw[0] & wzc & ~ae & ~tick & pd_s_q
    |=> tmr_q[0] == $past(tmr_q[0]))
    else $error("timeout count restarted");
  pk_clr_a: assert property (rd_fire & ridx == IDX_L_PK_HI & ~tick
    |=> pk_q[0] == 15'h0000)
    else $error("peak not cleared by high byte read");
  ovf_clr_a: assert property (rd_fire & ridx == IDX_STATUS & ~tick
    |=> ovf_q[0] == 3'h0 && ovf_q[1] == 3'h0)
    else $error("level flags not cleared by status read");
  pwr_clr_a: assert property (~cpwr |=> pk_q[1] == 15'h0000 && ovf_q[1] == 3'h0)
    else $error("monitors not cleared with converter off");
  done_one_a: assert property (pd_s_q & ipwr & ph_q == PH_RUN & (~wzc | lim_en)
    |=> done_q == 2'b11)
    else $error("done flags not forced high");
  init_zero_a: assert property (pd_s_q & ipwr & ph_q == PH_INIT |=> done_q == 2'b00)
    else $error("done flags high during start-up");

endmodule // pga_zero_cross_level_monitor

//--- rtl/pga_zc_pkg.sv
// Purpose: Shared constants for the gain timing and level monitor block
// Assumes: Register index = byte address / 4 on AXI4-Lite
// Notes: Timeouts and periods are counted in sample periods
package pga_zc_pkg;
  // Register indices
  localparam logic [5:0] IDX_POWER = 6'h01;
  localparam logic [5:0] IDX_ZC_CTRL = 6'h03;
  localparam logic [5:0] IDX_L_PK_LO = 6'h04;
  localparam logic [5:0] IDX_L_PK_HI = 6'h05;
  localparam logic [5:0] IDX_R_PK_LO = 6'h06;
  localparam logic [5:0] IDX_R_PK_HI = 6'h07;
  localparam logic [5:0] IDX_STATUS = 6'h08;
  localparam logic [5:0] IDX_AUTO = 6'h09;
  localparam logic [5:0] IDX_L_GAIN = 6'h0A;
  localparam logic [5:0] IDX_R_GAIN = 6'h0B;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'hE4;
  localparam logic [1:0] POWER_RST = 2'h3;
  localparam logic [1:0] AUTO_RST = 2'h0;
  localparam logic [6:0] GAIN_RST = 7'h30;
  // Control field positions
  localparam int B_COMMON_GAIN_WRITE = 7;
  localparam int B_GAIN_RANGE_SELECT = 6;
  localparam int B_NRTM = 4;
  localparam int B_WRITE_ZERO_CROSS_ENABLE = 3;
  localparam int B_LTM = 1;
  localparam int B_LIMITER_ZERO_CROSS_ENABLE = 0;
  // Own registers: power bits 1:0, auto bits 7:6
  localparam int B_IPWR = 0;
  localparam int B_CPWR = 1;
  localparam int B_LIMITER_ENABLE = 7;
  localparam int B_RECOVERY_ENABLE = 6;
  // Timeouts and limiter update periods in samples
  localparam logic [12:0] NRT0 = 13'h0201;
  localparam logic [12:0] NRT1 = 13'h0401;
  localparam logic [12:0] NRT2 = 13'h0801;
  localparam logic [12:0] NRT3 = 13'h1001;
  localparam logic [12:0] LTO0 = 13'h0081;
  localparam logic [12:0] LTO1 = 13'h0102;
  localparam logic [12:0] LTO2 = 13'h0204;
  localparam logic [12:0] LTO3 = 13'h0408;
  localparam logic [3:0] GAP0 = 4'h1;
  localparam logic [3:0] GAP1 = 4'h2;
  localparam logic [3:0] GAP2 = 4'h4;
  localparam logic [3:0] GAP3 = 4'h8;
  localparam logic [3:0] INIT_TICKS = 4'h8;
  // Level thresholds on 15-bit magnitude
  localparam logic [14:0] TH1 = 15'h2000;
  localparam logic [14:0] TH2 = 15'h3000;
  localparam logic [14:0] TH3 = 15'h4000;
  localparam logic [14:0] TH4 = 15'h5000;
  localparam logic [14:0] TH5 = 15'h680A;
  localparam logic [14:0] TH6 = 15'h7FFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PH_DOWN = 2'b00,
    PH_INIT = 2'b01,
    PH_RUN = 2'b10
  } phase_t;
endpackage

//--- verif/pga_zero_cross_level_monitor_test.sv
// Purpose: Self-checking bench for the gain timing and level monitor block
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: Frame clock ticks are made by the bench, eight mclk cycles each
`timescale 1ns/100ps
module pga_zero_cross_level_monitor_test import pga_zc_pkg::*;;
  logic mclk, rst_b, power_down_pin_b, frame_clk, auto_req, auto_lim;
  logic [15:0] left_sample, right_sample;
  logic [6:0] auto_gain, left_input_gain, right_input_gain;
  logic gain_range_select, auto_ready;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [14:0] th [6];
  int bad_count, samples_checked, cyc;

  pga_zero_cross_level_monitor dut (
    .mclk, .rst_b, .power_down_pin_b, .frame_clk, .left_sample, .right_sample,
    .auto_req, .auto_lim, .auto_gain, .left_input_gain, .right_input_gain,
    .gain_range_select, .auto_ready, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready
  );

  // Free running master clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("[FAIL] run length expected finish seen hang");
      results();
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write, channels released as each is taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a, w, ta, tw;
    a = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(negedge mclk);
      ta = awready === 1'b1;
      tw = wready === 1'b1;
      @(posedge mclk);
      if (ta) begin
        awvalid <= 1'b0;
        a = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    do @(negedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask

  // Bus read
  task automatic rd(input logic [5:0] idx);
    logic t;
    t = 1'b0;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge mclk);
      t = arready === 1'b1;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask

  // Read a register and compare the masked word
  task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] m,
                    input logic [7:0] e);
    rd(idx);
    chk(nm, {24'h000000, e}, got & {24'h000000, m});
  endtask

  // Sample ticks with held channel data
  task automatic tick(input int n, input logic [15:0] l, input logic [15:0] r);
    repeat (n) begin
      @(posedge mclk);
      left_sample <= l;
      right_sample <= r;
      frame_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      frame_clk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask

  // Pass or fail verdict
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    th = '{TH1, TH2, TH3, TH4, TH5, TH6};
    rst_b = 1'b0;
    power_down_pin_b = 1'b0;
    frame_clk = 1'b0;
    left_sample = 16'h0000;
    right_sample = 16'h0000;
    auto_req = 1'b0;
    auto_lim = 1'b0;
    auto_gain = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk("range select reset", 32'h1, 32'(gain_range_select));
    wr(IDX_ZC_CTRL, 8'h00);
    rc("ctrl while down", IDX_ZC_CTRL, 8'hFF, CTRL_RST);
    chk("read resp", 32'(RESP_OKAY), 32'(resp));
    @(posedge mclk);
    power_down_pin_b <= 1'b1;
    rc("status in start-up", IDX_STATUS, 8'hFF, 8'h00);
    rc("peak reset", IDX_L_PK_LO, 8'hFF, 8'h00);
    tick(12, 16'h0100, 16'h0100);
    rc("done after start-up", IDX_STATUS, 8'hC0, 8'hC0);
    wr(IDX_L_GAIN, 8'h40);
    chk("right follows left", 32'h40, 32'(right_input_gain));
    wr(IDX_R_GAIN, 8'h20);
    chk("left kept", 32'h40, 32'(left_input_gain));
    wr(IDX_ZC_CTRL, 8'h24);
    chk("range select line", 32'h0, 32'(gain_range_select));
    wr(IDX_L_GAIN, 8'h11);
    chk("right kept", 32'h20, 32'(right_input_gain));
    chk("left own", 32'h11, 32'(left_input_gain));
    // Write with byte lane 0 masked changes nothing
    wstrb <= 4'h0;
    wr(IDX_L_GAIN, 8'h7F);
    wstrb <= 4'hF;
    chk("masked write", 32'h11, 32'(left_input_gain));
    chk("masked write resp", 32'(RESP_OKAY), 32'(resp));
    // Gated writes: timeout, rewrite, zero crossing
    wr(IDX_ZC_CTRL, 8'h08);
    tick(2, 16'h0100, 16'h0100);
    wr(IDX_L_GAIN, 8'h50);
    rc("left done cleared", IDX_STATUS, 8'h40, 8'h00);
    tick(500, 16'h0100, 16'h0100);
    chk("left waits", 32'h11, 32'(left_input_gain));
    tick(20, 16'h0100, 16'h0100);
    chk("left on timeout", 32'h50, 32'(left_input_gain));
    rc("left done set", IDX_STATUS, 8'h40, 8'h40);
    wr(IDX_L_GAIN, 8'h60);
    tick(300, 16'h0100, 16'h0100);
    wr(IDX_L_GAIN, 8'h61);
    tick(200, 16'h0100, 16'h0100);
    chk("rewrite waits", 32'h50, 32'(left_input_gain));
    tick(20, 16'h0100, 16'h0100);
    chk("rewrite keeps count", 32'h61, 32'(left_input_gain));
    wr(IDX_R_GAIN, 8'h55);
    tick(1, 16'h0100, 16'h0100);
    chk("right waits", 32'h20, 32'(right_input_gain));
    tick(2, 16'h0100, 16'hFF00);
    chk("right at crossing", 32'h55, 32'(right_input_gain));
    // Idle channel written while the other waits gets a fresh count
    wr(IDX_L_GAIN, 8'h33);
    tick(100, 16'h0100, 16'h0100);
    wr(IDX_R_GAIN, 8'h44);
    tick(420, 16'h0100, 16'h0100);
    chk("left own timeout", 32'h33, 32'(left_input_gain));
    chk("right restarted", 32'h55, 32'(right_input_gain));
    tick(100, 16'h0100, 16'h0100);
    chk("right on timeout", 32'h44, 32'(right_input_gain));
    // Done flags forced by gain power off and by limiter mode
    wr(IDX_L_GAIN, 8'h22);
    wr(IDX_POWER, 8'h02);
    rc("done gain power off", IDX_STATUS, 8'hC0, 8'hC0);
    wr(IDX_POWER, 8'h03);
    wr(IDX_AUTO, 8'h80);
    rc("done limiter mode", IDX_STATUS, 8'hC0, 8'hC0);
    // Limiter immediate step and its spacing
    wr(IDX_ZC_CTRL, 8'h06);
    tick(10, 16'h0100, 16'h0100);
    @(posedge mclk);
    auto_req <= 1'b1;
    auto_lim <= 1'b1;
    auto_gain <= 7'h10;
    @(posedge mclk);
    auto_req <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("limiter step", 32'h10, 32'(left_input_gain));
    chk("spacing starts", 32'h0, 32'(auto_ready));
    tick(6, 16'h0100, 16'h0100);
    chk("spacing runs", 32'h0, 32'(auto_ready));
    tick(3, 16'h0100, 16'h0100);
    chk("spacing done", 32'h1, 32'(auto_ready));
    // Limiter step gated by zero crossing, shortest timeout
    wr(IDX_ZC_CTRL, 8'h01);
    @(posedge mclk);
    auto_req <= 1'b1;
    auto_gain <= 7'h0C;
    @(posedge mclk);
    auto_req <= 1'b0;
    tick(1, 16'h0100, 16'hFF00);
    chk("limiter right crossing", 32'h0C, 32'(right_input_gain));
    chk("limiter left waits", 32'h10, 32'(left_input_gain));
    tick(126, 16'h0100, 16'hFF00);
    chk("limiter before timeout", 32'h10, 32'(left_input_gain));
    tick(2, 16'h0100, 16'hFF00);
    chk("limiter on timeout", 32'h0C, 32'(left_input_gain));
    wr(IDX_AUTO, 8'h00);
    // Peak bytes, clear on high byte read, clear on converter off
    rd(IDX_L_PK_HI);
    rd(IDX_R_PK_HI);
    tick(1, 16'hEDCC, 16'h0567);
    rc("left peak low", IDX_L_PK_LO, 8'hFF, 8'h34);
    rc("left peak high", IDX_L_PK_HI, 8'hFF, 8'h12);
    rc("right peak low", IDX_R_PK_LO, 8'hFF, 8'h67);
    rc("right peak high", IDX_R_PK_HI, 8'hFF, 8'h05);
    rc("left peak cleared", IDX_L_PK_HI, 8'hFF, 8'h00);
    tick(1, 16'h8000, 16'h7FFF);
    rc("left peak max low", IDX_L_PK_LO, 8'hFF, 8'hFF);
    rc("left peak max high", IDX_L_PK_HI, 8'hFF, 8'h7F);
    tick(1, 16'h8000, 16'h8000);
    wr(IDX_POWER, 8'h01);
    rc("peak conv off", IDX_R_PK_LO, 8'hFF, 8'h00);
    rc("level conv off", IDX_STATUS, 8'h3F, 8'h00);
    wr(IDX_POWER, 8'h03);
    // Level codes on every threshold, read clears, maximum held
    rd(IDX_STATUS);
    for (int k = 0; k < 6; k++) begin
      tick(1, {1'b0, th[k]}, 16'h0001 - {1'b0, th[k]});
      rc("level code", IDX_STATUS, 8'h3F, {2'b00, 3'(k), 3'(k + 1)});
    end
    tick(1, 16'h7FFF, 16'h7FFF);
    tick(1, 16'h0000, 16'h0000);
    rc("level held", IDX_STATUS, 8'h3F, 8'h36);
    // Unmapped places
    rd(6'h02);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(resp));
    chk("unmapped read data", 32'h0, got);
    wr(6'h0C, 8'h5A);
    chk("unmapped write resp", 32'(RESP_SLVERR), 32'(resp));
    results();
  end
endmodule // pga_zero_cross_level_monitor_test
